// File: hdl/l1_cache_pkg.sv
// Constants and types shared by the first-level cache control block.
// Notes on behaviour
// R1: Split instruction and data caches, 32 KB each, two ways, 32-byte lines.
// R2: Instruction side has a 64-entry translation buffer, data side 128 entries.
// R3: A 64-byte sector holds two lines under one tag, states kept per line.
// R4: Instruction lines keep one valid bit, data lines two coherency bits.
// R5: Data lines are Modified, Exclusive, Shared or Invalid.
// R6: A write to an Exclusive data line makes it Modified.
// R7: Own snoops and external inquiries both keep line states correct; the own snoop here runs only on data write hits, not on write misses.
// R8: Instruction fills produce per-byte distance to next instruction start, 1 to 15.
// R9: Predecode kept in its own array beside each byte, delivered with the line.
// R10: Lines are fetched from memory by burst bus transactions.
// R11: No-writethrough is control bit 29, cache-disable bit 30, in every mode.
// R12: Both clear: fill on read miss, write misses and Shared writes go to memory.
// R13: Cache-disable clear with no-writethrough set is refused as a protection fault.
// R14: Cache-disable set alone: reads hit, no fills, writes as in normal mode.
// R15: Both set: no fills, write hits stay in cache, write misses go to memory.
// R16: Page cache-disable and write-through attributes come from the page entry.
// R17: Page write-through output is high only with attribute and paging both set.
// R18: Page cache-disable output high with cache-disable, else attribute and paging.
// R19: Cacheable-cycle output low for writebacks or uninhibited unlocked uncached-free reads.
// R20: A confirmed cacheable read bursts four readies, otherwise one ready.
// R21: Instruction lines replaced least recently used, data lines least recently allocated.
// R22: Hardware reset marks every line invalid before any lookup.
`default_nettype none

package l1_cache_pkg;
    localparam int CACHE_BYTES    = 32768;
    localparam int WAYS           = 2;
    localparam int LINE_BYTES     = 32;
    localparam int SECTOR_BYTES   = 64;
    localparam int ITLB_ENTRIES   = 64;
    localparam int DTLB_ENTRIES   = 128;
    localparam int BURST_BEATS    = 4;
    localparam int BEAT_BYTES     = 8;
    localparam int MAX_INSN_BYTES = 15;
    localparam int PD_W           = 4;
    localparam int PAGE_SHIFT     = 12;
    localparam int VPN_W          = 20;

    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] TEST_OFF = 12'h004;
    localparam logic [11:0] STAT_OFF = 12'h008;

    localparam int NW_BIT    = 29;
    localparam int CD_BIT    = 30;
    localparam int PG_BIT    = 31;
    localparam int CI_BIT    = 0;
    localparam int FAULT_BIT = 0;
    localparam int MODE_LSB  = 1;
    localparam int BUSY_BIT  = 3;

    localparam logic CD_RST = 1'h1;
    localparam logic NW_RST = 1'h1;
    localparam logic PG_RST = 1'h0;
    localparam logic CI_RST = 1'h0;

    typedef enum logic [1:0] {
        ST_INVALID,
        ST_SHARED,
        ST_EXCLUSIVE,
        ST_MODIFIED
    } mesi_t;
endpackage

`default_nettype wire

// File: hdl/predecode_distance.sv
// Per-byte distance to the next instruction start within one line.
`default_nettype none

module predecode_distance (
    input  wire logic [l1_cache_pkg::LINE_BYTES-1:0]                   starts_in,
    output logic      [l1_cache_pkg::LINE_BYTES*l1_cache_pkg::PD_W-1:0] dist_out
);
    localparam int NB = l1_cache_pkg::LINE_BYTES;

    // A zero distance means no start lies within the next 15 bytes of this line.
    always_comb begin
        dist_out = '0;
        for (int i = 0; i < NB; i++) begin
            for (int k = l1_cache_pkg::MAX_INSN_BYTES; k >= 1; k--) begin
                if (i + k < NB && starts_in[i+k]) begin
                    dist_out[i*l1_cache_pkg::PD_W +: l1_cache_pkg::PD_W] =
                        l1_cache_pkg::PD_W'(k); // [R8]
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: hdl/l1_cache_ctl.sv
// Tag, state, translation and cacheability control for the split first-level caches.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`default_nettype none

module l1_cache_ctl #(
    parameter int SETS   = l1_cache_pkg::CACHE_BYTES / (l1_cache_pkg::WAYS * l1_cache_pkg::SECTOR_BYTES),
    parameter int ITLB_N = l1_cache_pkg::ITLB_ENTRIES,
    parameter int DTLB_N = l1_cache_pkg::DTLB_ENTRIES
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [11:0]  paddr_in,
    input  wire logic [31:0]  pwdata_in,
    output logic      [31:0]  prdata_out,
    output logic              pready_out,
    output logic              pslverr_out,
    input  wire logic         acc_valid_in,
    input  wire logic         acc_instr_in,
    input  wire logic         acc_write_in,
    input  wire logic         acc_locked_in,
    input  wire logic         acc_writeback_in,
    input  wire logic [31:0]  acc_addr_in,
    input  wire logic         tlb_fill_in,
    input  wire logic         tlb_fill_instr_in,
    input  wire logic [19:0]  tlb_vpn_in,
    input  wire logic [19:0]  tlb_ppn_in,
    input  wire logic         tlb_pcd_in,
    input  wire logic         tlb_pwt_in,
    input  wire logic         burst_ready_n_in,
    input  wire logic         cache_enable_in_n,
    input  wire logic [7:0]   fill_starts_in,
    input  wire logic         snoop_valid_in,
    input  wire logic         snoop_inv_in,
    input  wire logic [31:0]  snoop_addr_in,
    output logic              acc_done_out,
    output logic              acc_hit_out,
    output logic              acc_way_out,
    output logic      [1:0]   acc_state_out,
    output logic              tlb_miss_out,
    output logic      [31:0]  phys_addr_out,
    output logic              mem_write_out,
    output logic              fill_active_out,
    output logic              burst_out,
    output logic              page_write_through_out,
    output logic              page_cache_disable_out,
    output logic              cache_cycle_n_out,
    output logic      [127:0] predecode_out,
    output logic              gp_fault_out,
    output logic              snoop_hit_out,
    output logic              snoop_hitm_out
);
    localparam int SET_W = $clog2(SETS);
    localparam int TAG_W = 32 - 6 - SET_W;
    localparam int IIW   = $clog2(ITLB_N);
    localparam int DIW   = $clog2(DTLB_N);
    localparam int PDB   = l1_cache_pkg::LINE_BYTES * l1_cache_pkg::PD_W;
    localparam int TE_W  = 1 + 2 * l1_cache_pkg::VPN_W + 2;

    typedef l1_cache_pkg::mesi_t mesi_t;
    typedef enum logic [1:0] {S_IDLE, S_LOOK, S_BUS} fsm_t;

    function automatic logic [SET_W-1:0] set_of(input logic [31:0] a);
        return a[6 +: SET_W];
    endfunction

    function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
        return a[31 -: TAG_W];
    endfunction

    // Translation entry layout: valid, vpn, ppn, pcd, pwt.
    function automatic logic [TE_W-1:0] te_pack(input logic [19:0] v, input logic [19:0] p,
                                                 input logic c, input logic w);
        return {1'h1, v, p, c, w};
    endfunction

    logic            cd_r;
    logic            nw_r;
    logic            pg_r;
    logic            ci_r;
    fsm_t            st_r;
    logic [31:0]     rq_addr_r;
    logic            rq_instr_r;
    logic            rq_write_r;
    logic            rq_locked_r;
    logic            rq_wb_r;
    logic            alloc_r;
    logic            vic_r;
    logic            sec_rep_r;
    mesi_t           fill_st_r;
    logic [1:0]      beat_r;
    logic [31:0]     starts_r;

    logic            i_val [SETS][2][2];
    mesi_t           d_st  [SETS][2][2];
    logic [TAG_W-1:0] i_tag [SETS][2];
    logic [TAG_W-1:0] d_tag [SETS][2];
    logic            i_lru [SETS];
    logic            d_lra [SETS];
    logic [PDB-1:0]  pd_mem [SETS][2][2];
    logic [TE_W-1:0] itlb [ITLB_N];
    logic [TE_W-1:0] dtlb [DTLB_N];

    // APB: setup, one wait cycle in access phase, then pready for one cycle.
    logic apb_acc;
    logic apb_wr_go;
    logic bad_mode;
    logic mapped;
    assign apb_acc   = psel_in & penable_in & ~pready_out;
    assign apb_wr_go = psel_in & penable_in & pready_out & pwrite_in;
    assign mapped    = paddr_in == l1_cache_pkg::CTRL_OFF || paddr_in == l1_cache_pkg::TEST_OFF ||
                       paddr_in == l1_cache_pkg::STAT_OFF;
    assign bad_mode  = paddr_in == l1_cache_pkg::CTRL_OFF &&
                       !pwdata_in[l1_cache_pkg::CD_BIT] && pwdata_in[l1_cache_pkg::NW_BIT];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out  <= 1'h0;
            pslverr_out <= 1'h0;
            prdata_out  <= 32'h0;
        end else begin
            pready_out  <= apb_acc;
            pslverr_out <= apb_acc & (~mapped | (pwrite_in & bad_mode));
            prdata_out  <= 32'h0;
            if (apb_acc && !pwrite_in) begin
                case (paddr_in)
                    l1_cache_pkg::CTRL_OFF: begin
                        prdata_out[l1_cache_pkg::NW_BIT] <= nw_r;
                        prdata_out[l1_cache_pkg::CD_BIT] <= cd_r;
                        prdata_out[l1_cache_pkg::PG_BIT] <= pg_r;
                    end
                    l1_cache_pkg::TEST_OFF: prdata_out[l1_cache_pkg::CI_BIT] <= ci_r;
                    l1_cache_pkg::STAT_OFF: begin
                        prdata_out[l1_cache_pkg::FAULT_BIT]   <= gp_fault_out;
                        prdata_out[l1_cache_pkg::MODE_LSB +: 2] <= {cd_r, nw_r};
                        prdata_out[l1_cache_pkg::BUSY_BIT]    <= st_r != S_IDLE;
                    end
                    default: prdata_out <= 32'h0;
                endcase
            end
        end
    end

    // Control bits; the refused combination leaves the mode unchanged.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cd_r <= l1_cache_pkg::CD_RST;
            nw_r <= l1_cache_pkg::NW_RST;
            pg_r <= l1_cache_pkg::PG_RST;
            ci_r <= l1_cache_pkg::CI_RST;
        end else if (apb_wr_go) begin
            if (paddr_in == l1_cache_pkg::CTRL_OFF && !bad_mode) begin // [R13]
                cd_r <= pwdata_in[l1_cache_pkg::CD_BIT]; // [R11]
                nw_r <= pwdata_in[l1_cache_pkg::NW_BIT]; // [R11]
                pg_r <= pwdata_in[l1_cache_pkg::PG_BIT];
            end
            if (paddr_in == l1_cache_pkg::TEST_OFF) begin
                ci_r <= pwdata_in[l1_cache_pkg::CI_BIT];
            end
        end
    end

    // Fault flag: a new fault wins over a write-one clear in the same cycle.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gp_fault_out <= 1'h0;
        end else if (apb_wr_go && bad_mode) begin
            gp_fault_out <= 1'h1; // [R13]
        end else if (apb_wr_go && paddr_in == l1_cache_pkg::STAT_OFF &&
                     pwdata_in[l1_cache_pkg::FAULT_BIT]) begin
            gp_fault_out <= 1'h0;
        end
    end

    // Translation buffers, one per side, direct mapped on the low page bits.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < ITLB_N; i++) itlb[i] <= '0;
            for (int i = 0; i < DTLB_N; i++) dtlb[i] <= '0;
        end else if (tlb_fill_in) begin
            if (tlb_fill_instr_in) begin
                itlb[tlb_vpn_in[IIW-1:0]] <= te_pack(tlb_vpn_in, tlb_ppn_in, tlb_pcd_in, tlb_pwt_in); // [R2]
            end else begin
                dtlb[tlb_vpn_in[DIW-1:0]] <= te_pack(tlb_vpn_in, tlb_ppn_in, tlb_pcd_in, tlb_pwt_in); // [R2]
            end
        end
    end

    // Lookup of the held request.
    logic [TE_W-1:0]  te;
    logic             tlb_ok;
    logic [31:0]      phys;
    logic             pcd_sig;
    logic             pwt_sig;
    logic             cacheable;
    logic [SET_W-1:0] ls;
    logic [TAG_W-1:0] lt;
    logic             ll;
    logic [1:0]       sec_v;
    logic [1:0]       tmatch;
    logic             match;
    logic             mw;
    mesi_t            lst;
    logic             hit;
    logic             victim;

    always_comb begin
        te = rq_instr_r ? itlb[rq_addr_r[l1_cache_pkg::PAGE_SHIFT +: IIW]]
                        : dtlb[rq_addr_r[l1_cache_pkg::PAGE_SHIFT +: DIW]];
        tlb_ok = ~pg_r | (te[TE_W-1] && te[TE_W-2 -: 20] == rq_addr_r[31:12]);
        phys = pg_r ? {te[21:2], rq_addr_r[11:0]} : rq_addr_r;
        pwt_sig = te[0] & pg_r; // [R16] [R17]
        pcd_sig = cd_r | (te[1] & pg_r); // [R16] [R18]
        cacheable = rq_wb_r | (~ci_r & ~rq_write_r & ~rq_locked_r & ~pcd_sig); // [R19]
        ls = set_of(phys);
        lt = tag_of(phys);
        ll = phys[5];
        for (int w = 0; w < 2; w++) begin
            sec_v[w] = rq_instr_r ? (i_val[ls][w][0] | i_val[ls][w][1])
                                  : (d_st[ls][w][0] != l1_cache_pkg::ST_INVALID ||
                                     d_st[ls][w][1] != l1_cache_pkg::ST_INVALID);
            tmatch[w] = sec_v[w] && (rq_instr_r ? i_tag[ls][w] : d_tag[ls][w]) == lt; // [R3]
        end
        match = |tmatch;
        mw = tmatch[1];
        if (rq_instr_r) begin
            lst = i_val[ls][mw][ll] ? l1_cache_pkg::ST_SHARED : l1_cache_pkg::ST_INVALID; // [R4]
        end else begin
            lst = d_st[ls][mw][ll];
        end
        hit = match && lst != l1_cache_pkg::ST_INVALID;
        if (match) victim = mw;
        else if (!sec_v[0]) victim = 1'h0;
        else if (!sec_v[1]) victim = 1'h1;
        else victim = rq_instr_r ? i_lru[ls] : d_lra[ls]; // [R21]
    end

    logic         rdy;
    logic         last_beat;
    logic [31:0]  starts_nxt;
    logic [PDB-1:0] pd_new;
    logic         fill_end;
    logic [SET_W-1:0] fs;
    assign rdy        = st_r == S_BUS && !burst_ready_n_in;
    assign last_beat  = beat_r == 2'(l1_cache_pkg::BURST_BEATS - 1);
    assign fs         = set_of(phys_addr_out);
    always_comb begin
        starts_nxt = starts_r;
        starts_nxt[beat_r*l1_cache_pkg::BEAT_BYTES +: l1_cache_pkg::BEAT_BYTES] = fill_starts_in;
    end
    // The first ready decides single or burst; a burst ends on its fourth ready.
    assign fill_end = rdy && (beat_r == 2'h0 ? !(alloc_r && !cache_enable_in_n) : last_beat); // [R20]

    predecode_distance u_pd (
        .starts_in (starts_nxt),
        .dist_out  (pd_new)
    );

    // Request sequencer and its outputs.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= S_IDLE;
            {rq_instr_r, rq_write_r, rq_locked_r, rq_wb_r} <= 4'h0;
            rq_addr_r <= 32'h0;
            {alloc_r, vic_r, sec_rep_r} <= 3'h0;
            fill_st_r <= l1_cache_pkg::ST_INVALID;
            beat_r <= 2'h0;
            starts_r <= 32'h0;
            {acc_done_out, acc_hit_out, acc_way_out, tlb_miss_out} <= 4'h0;
            {mem_write_out, fill_active_out, burst_out} <= 3'h0;
            acc_state_out <= 2'h0;
            phys_addr_out <= 32'h0;
            page_write_through_out <= 1'h0;
            page_cache_disable_out <= 1'h0;
            cache_cycle_n_out <= 1'h1;
            predecode_out <= '0;
        end else begin
            acc_done_out  <= 1'h0;
            tlb_miss_out  <= 1'h0;
            mem_write_out <= 1'h0;
            case (st_r)
                S_IDLE: begin
                    if (acc_valid_in) begin
                        rq_addr_r   <= acc_addr_in;
                        rq_instr_r  <= acc_instr_in;
                        rq_write_r  <= acc_write_in & ~acc_instr_in;
                        rq_locked_r <= acc_locked_in;
                        rq_wb_r     <= acc_writeback_in;
                        st_r        <= S_LOOK;
                    end
                end
                S_LOOK: begin
                    phys_addr_out <= phys;
                    page_write_through_out <= pwt_sig; // [R17]
                    page_cache_disable_out <= pcd_sig; // [R18]
                    cache_cycle_n_out <= ~cacheable; // [R19]
                    acc_hit_out   <= hit & tlb_ok;
                    acc_way_out   <= mw;
                    acc_state_out <= lst;
                    predecode_out <= rq_instr_r ? pd_pick(ls, mw, ll) : '0; // [R9]
                    vic_r     <= victim;
                    sec_rep_r <= ~match;
                    fill_st_r <= pwt_sig ? l1_cache_pkg::ST_SHARED : l1_cache_pkg::ST_EXCLUSIVE;
                    if (!tlb_ok) begin
                        tlb_miss_out <= 1'h1;
                        acc_done_out <= 1'h1;
                        st_r <= S_IDLE;
                    end else if (rq_write_r) begin
                        // Write hits go to memory only for Shared or write-through lines, and only with no-writethrough clear.
                        mem_write_out <= ~hit | ((lst == l1_cache_pkg::ST_SHARED | pwt_sig) & ~nw_r); // [R12] [R14] [R15]
                        acc_done_out <= 1'h1;
                        st_r <= S_IDLE;
                    end else if (hit || rq_wb_r) begin
                        acc_done_out <= 1'h1;
                        st_r <= S_IDLE;
                    end else begin
                        alloc_r <= ~cd_r & cacheable; // [R12] [R14] [R15]
                        fill_active_out <= 1'h1; // [R10]
                        beat_r <= 2'h0;
                        st_r <= S_BUS;
                    end
                end
                S_BUS: begin
                    if (rdy) begin
                        starts_r <= starts_nxt;
                        beat_r <= beat_r + 2'h1;
                        if (beat_r == 2'h0) burst_out <= alloc_r & ~cache_enable_in_n; // [R20]
                    end
                    if (fill_end) begin
                        fill_active_out <= 1'h0;
                        burst_out <= 1'h0;
                        acc_done_out <= 1'h1;
                        acc_way_out <= vic_r;
                        if (rq_instr_r && beat_r != 2'h0) predecode_out <= pd_new; // [R9]
                        st_r <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    function automatic logic [PDB-1:0] pd_pick(input logic [SET_W-1:0] s, input logic w, input logic l);
        return pd_mem[s][w][l];
    endfunction

    // Line state, tags and replacement; external inquiries apply last.
    logic             fill_commit;
    logic             wr_hit;
    logic [SET_W-1:0] ss;
    logic [TAG_W-1:0] stg;
    assign fill_commit = fill_end && beat_r != 2'h0;
    assign wr_hit = st_r == S_LOOK && tlb_ok && rq_write_r && hit;
    assign ss  = set_of(snoop_addr_in);
    assign stg = tag_of(snoop_addr_in);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int s = 0; s < SETS; s++) begin
                i_lru[s] <= 1'h0;
                d_lra[s] <= 1'h0;
                for (int w = 0; w < 2; w++) begin
                    i_tag[s][w] <= '0;
                    d_tag[s][w] <= '0;
                    for (int l = 0; l < 2; l++) begin
                        i_val[s][w][l] <= 1'h0; // [R22]
                        d_st[s][w][l]  <= l1_cache_pkg::ST_INVALID; // [R22]
                    end
                end
            end
            snoop_hit_out  <= 1'h0;
            snoop_hitm_out <= 1'h0;
        end else begin
            if (st_r == S_LOOK && tlb_ok && hit && rq_instr_r) i_lru[ls] <= ~mw; // [R21]
            if (wr_hit) begin
                if (lst == l1_cache_pkg::ST_EXCLUSIVE) d_st[ls][mw][ll] <= l1_cache_pkg::ST_MODIFIED; // [R6]
                for (int w = 0; w < 2; w++) begin
                    // Own snoop: stale code bytes must not survive a data write that hits the data cache.
                    if (i_tag[ls][w] == lt) i_val[ls][w][ll] <= 1'h0; // [R7]
                end
            end
            if (fill_commit && rq_instr_r) begin
                i_tag[fs][vic_r] <= tag_of(phys_addr_out);
                i_val[fs][vic_r][phys_addr_out[5]] <= 1'h1; // [R1]
                if (sec_rep_r) i_val[fs][vic_r][~phys_addr_out[5]] <= 1'h0; // [R3]
                i_lru[fs] <= ~vic_r; // [R21]
            end
            if (fill_commit && !rq_instr_r) begin
                d_tag[fs][vic_r] <= tag_of(phys_addr_out);
                d_st[fs][vic_r][phys_addr_out[5]] <= fill_st_r; // [R5]
                if (sec_rep_r) d_st[fs][vic_r][~phys_addr_out[5]] <= l1_cache_pkg::ST_INVALID; // [R3]
                d_lra[fs] <= ~vic_r; // [R21]
            end
            snoop_hit_out  <= 1'h0;
            snoop_hitm_out <= 1'h0;
            if (snoop_valid_in) begin
                for (int w = 0; w < 2; w++) begin
                    if (i_tag[ss][w] == stg && i_val[ss][w][snoop_addr_in[5]]) begin
                        snoop_hit_out <= 1'h1;
                        if (snoop_inv_in) i_val[ss][w][snoop_addr_in[5]] <= 1'h0; // [R7]
                    end
                    if (d_tag[ss][w] == stg && d_st[ss][w][snoop_addr_in[5]] != l1_cache_pkg::ST_INVALID) begin
                        snoop_hit_out <= 1'h1;
                        snoop_hitm_out <= d_st[ss][w][snoop_addr_in[5]] == l1_cache_pkg::ST_MODIFIED;
                        d_st[ss][w][snoop_addr_in[5]] <= snoop_inv_in ? l1_cache_pkg::ST_INVALID
                                                                      : l1_cache_pkg::ST_SHARED; // [R7]
                    end
                end
            end
        end
    end

    // Predecode array sits beside the tag store, written on instruction fills.
    always_ff @(posedge clk_in) begin
        if (fill_commit && rq_instr_r) begin
            pd_mem[fs][vic_r][phys_addr_out[5]] <= pd_new; // [R8] [R9]
        end
    end
endmodule

`default_nettype wire

// File: bench/l1_cache_ctl_chk.sv
// Port-level assertions for the cache control block.
`default_nettype none
module l1_cache_ctl_chk(input wire logic clk_in, rst_in, psel_in, penable_in, pready_out, pslverr_out,
    gp_fault_out, acc_done_out, fill_active_out, burst_out, mem_write_out, acc_writeback_in, cache_cycle_n_out);
default clocking @(posedge clk_in); endclocking
default disable iff (rst_in);
apb_wait_a: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out) else $error("wait");
rdy_once_a: assert property (pready_out |=> !pready_out) else $error("ready");
done_once_a: assert property (acc_done_out |=> !acc_done_out) else $error("done");
fill_end_a: assert property ($fell(fill_active_out) |-> acc_done_out) else $error("end");
burst_in_a: assert property (burst_out |-> fill_active_out) else $error("burst");
mem_wr_a: assert property (mem_write_out |-> acc_done_out) else $error("memw");
fault_src_a: assert property ($rose(gp_fault_out) |-> $past(pslverr_out)) else $error("gp");
wb_cache_a: assert property (acc_done_out && acc_writeback_in |-> !cache_cycle_n_out) else $error("wb");
cover property (burst_out);
cover property (gp_fault_out);
cover property (acc_done_out && acc_writeback_in);
endmodule
bind l1_cache_ctl l1_cache_ctl_chk u_l1_cache_ctl_chk(.*);
`default_nettype wire

// File: bench/sys_logic_model.sv
// System-logic stand-in answering read cycles with ready strobes.
`default_nettype none
module sys_logic_model(
    input  wire logic clk_in, rst_in, fill_active_out, slow,
    output logic      burst_ready_n_in, cache_enable_in_n);
    logic tog_r;
    assign cache_enable_in_n = 1'h0;
    // Slow mode answers only every other cycle, stretching the burst.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tog_r <= 1'h0;
            burst_ready_n_in <= 1'h1;
        end else begin
            tog_r <= ~tog_r;
            burst_ready_n_in <= !(fill_active_out && (!slow || tog_r));
        end
    end
endmodule
`default_nettype wire

// File: bench/l1_sectored_cache_control_test.sv
// Self-checking bench for the cache control block.
`default_nettype none
module l1_sectored_cache_control_test;
timeunit 1ns; timeprecision 1ns;
logic clk_in='0,rst_in='1,psel_in='0,penable_in='0,pwrite_in='0,acc_valid_in='0,acc_instr_in='0;
logic acc_write_in='0,acc_locked_in='0,acc_writeback_in='0,tlb_fill_in='0,tlb_fill_instr_in='0,tlb_pcd_in='0;
logic tlb_pwt_in='0,snoop_valid_in='0,snoop_inv_in='0,slow='0,pready_out,pslverr_out,acc_done_out,acc_hit_out;
logic acc_way_out,tlb_miss_out,mem_write_out,fill_active_out,burst_out,page_write_through_out;
logic page_cache_disable_out,cache_cycle_n_out,gp_fault_out,snoop_hit_out,snoop_hitm_out,burst_ready_n_in;
logic cache_enable_in_n; logic [11:0] paddr_in='0; logic [19:0] tlb_vpn_in='0,tlb_ppn_in='0;
logic [7:0] fill_starts_in=8'h01; logic [1:0] acc_state_out; logic [127:0] predecode_out;
logic [31:0] pwdata_in='0,acc_addr_in='0,snoop_addr_in='0,rd,prdata_out,phys_addr_out;
int failures=0,cmp_count=0,beats=0; logic err;
always #5 clk_in=~clk_in;
always @(posedge clk_in) if (fill_active_out && !burst_ready_n_in) beats<=beats+1;
l1_cache_ctl u_l1_cache_ctl(.*);
sys_logic_model u_sys_logic_model(.*);
task chk(input logic [31:0] s,e,input string n);
    cmp_count++;
    if (s!==e) begin failures++; $display("[ERR] %s exp %h got %h",n,e,s); end
endtask
task apb(input logic w,input logic [11:0] a,input logic [31:0] d);
    @(posedge clk_in) {psel_in,pwrite_in,paddr_in,pwdata_in}<={1'h1,w,a,d};
    @(posedge clk_in) penable_in<=1'h1;
    do @(posedge clk_in); while (pready_out!==1'h1);
    rd=prdata_out; err=pslverr_out; {psel_in,penable_in}<=2'h0;
endtask
task acc(input logic w,b,input logic [31:0] a);
    @(posedge clk_in) {acc_valid_in,acc_write_in,acc_writeback_in,acc_addr_in}<={1'h1,w,b,a};
    @(posedge clk_in) acc_valid_in<=1'h0;
    do @(posedge clk_in); while (acc_done_out!==1'h1);
endtask
task t_regs;
    apb(1'h1,12'h000,32'h2000_0000); chk(err,1'h1,"slverr");
    apb(1'h0,12'h000,32'h0);
    chk(rd,32'h6000_0000,"ctl");
    chk(gp_fault_out,1'h1,"gp");
    $display("regs end");
endtask
task t_fill;
    apb(1'h1,12'h000,32'h8000_0000); beats<=0;
    @(posedge clk_in) {tlb_fill_in,tlb_vpn_in,tlb_ppn_in}<={1'h1,20'h00001,20'h00005};
    @(posedge clk_in) tlb_fill_in<=1'h0;
    acc(1'h0,1'h0,32'h1040); chk(beats,32'h4,"beats");
    chk(phys_addr_out,32'h5040,"phys");
    acc(1'h1,1'h0,32'h1048); chk(mem_write_out,1'h0,"wr hit");
    acc(1'h0,1'h0,32'h1040); chk(acc_state_out,2'h3,"mod");
    chk(acc_hit_out,1'h1,"hit");
    @(posedge clk_in) {snoop_valid_in,snoop_inv_in,snoop_addr_in}<={1'h1,1'h1,32'h5040};
    @(posedge clk_in) snoop_valid_in<=1'h0;
    @(posedge clk_in) chk(snoop_hitm_out,1'h1,"hitm");
    $display("fill end");
endtask
task t_modes;
    apb(1'h1,12'h000,32'hC000_0000); beats<=0; slow<=1'h1;
    acc(1'h0,1'h0,32'h1400); chk(beats,32'h1,"beats");
    chk(page_cache_disable_out,1'h1,"page cache disable");
    chk(page_write_through_out,1'h0,"page write through");
    acc(1'h0,1'h1,32'h1400); chk(cache_cycle_n_out,1'h0,"wb");
    $display("modes end");
endtask
task give_verdict;
    $display("compares %0d mismatches %0d",cmp_count,failures);
    if (failures==0 && cmp_count>0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
endtask
initial begin #20000 failures++; give_verdict; end
initial begin
    repeat (2) @(posedge clk_in);
    rst_in<=1'h0;
    t_regs; t_fill; t_modes;
    give_verdict;
end
endmodule
`default_nettype wire
